// ### design/dlfs_status_bank.sv
// fault and warning status bank for a dual-channel led driver
`timescale 1ns/1ps
module dlfs_status_bank
    import dlfs_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    // comparator causes, asynchronous
    input  wire logic       ch2_low_switch_overcurrent_i,
    input  wire logic       ch2_high_switch_overcurrent_i,
    input  wire logic       ch2_output_shorted_i,
    input  wire logic       ch2_loop_node_overvoltage_i,
    input  wire logic       ch1_low_switch_overcurrent_i,
    input  wire logic       ch1_high_switch_overcurrent_i,
    input  wire logic       ch1_output_shorted_i,
    input  wire logic       ch1_loop_node_overvoltage_i,
    input  wire logic       ch2_thermal_protect_i,
    input  wire logic       ch2_bootstrap_low_i,
    input  wire logic       ch2_max_duty_flag_i,
    input  wire logic       ch1_thermal_protect_i,
    input  wire logic       ch1_bootstrap_low_i,
    input  wire logic       ch1_max_duty_flag_i,
    input  wire logic       analog_rail_low_i,
    input  wire logic       thermal_warning_flag_i,
    // supervisor events, same clock
    input  wire logic       watchdog_expiry_i,
    input  wire logic       standalone_enter_i,
    input  wire logic       standalone_clear_i,
    // serial host read port
    input  wire logic       rd_cmd_i,
    input  wire logic [7:0] rd_addr_i,
    input  wire logic       rd_resp_done_i,
    output logic      [7:0] rd_data_o,
    // channel control
    input  wire logic [1:0] ch_enable_req_i,
    output logic      [1:0] ch_enable_o,
    output logic            fallback_operation_o,
    output logic      [1:0] fault_summary_o
);
    logic [DLFS_CUR_W-1:0]  cur_async;
    logic [DLFS_CUR_W-1:0]  cur_cause;
    logic [DLFS_CUR_W-1:0]  cur_flag;
    logic [DLFS_SUP_W-1:0]  sup_async;
    logic [DLFS_SUP_W-1:0]  sup_cause;
    logic [DLFS_SUP_W-1:0]  sup_flag;
    logic [DLFS_MISC_W-1:0] misc_async;
    logic [DLFS_MISC_W-1:0] misc_cause;
    logic [DLFS_MISC_W-1:0] misc_flag;
    logic [7:0]             rd_addr_ff;
    logic [7:0]             rd_data_ff;
    logic [1:0]             watchdog_count_ff;
    logic                   power_cycle_ff;
    logic                   standalone_ff;
    logic                   clr_cur;
    logic                   clr_sup;
    logic                   clr_sys;
    logic                   ch1_fault;
    logic                   ch2_fault;
    logic [7:0]             sys_byte;
    // next values of the supervisor and read-path registers
    logic [1:0]             nxt_watchdog_count;
    logic                   nxt_power_cycle;
    logic                   nxt_standalone;
    logic [7:0]             nxt_rd_addr;
    logic [7:0]             nxt_rd_data;

    // causes packed at their register positions
    always_comb begin
        cur_async                     = '0;
        cur_async[DLFS_B_CH2_LOW_OC]  = ch2_low_switch_overcurrent_i;
        cur_async[DLFS_B_CH1_LOW_OC]  = ch1_low_switch_overcurrent_i;
        cur_async[DLFS_B_CH2_HIGH_OC] = ch2_high_switch_overcurrent_i;
        cur_async[DLFS_B_CH1_HIGH_OC] = ch1_high_switch_overcurrent_i;
        cur_async[DLFS_B_CH2_SHORT]   = ch2_output_shorted_i;
        cur_async[DLFS_B_CH1_SHORT]   = ch1_output_shorted_i;
        cur_async[DLFS_B_CH2_LOOP_OV] = ch2_loop_node_overvoltage_i;
        cur_async[DLFS_B_CH1_LOOP_OV] = ch1_loop_node_overvoltage_i;
    end

    always_comb begin
        sup_async                     = '0;
        sup_async[DLFS_B_CH2_BOOT]    = ch2_bootstrap_low_i;
        sup_async[DLFS_B_CH1_BOOT]    = ch1_bootstrap_low_i;
        sup_async[DLFS_B_CH2_THERM]   = ch2_thermal_protect_i;
        sup_async[DLFS_B_CH1_THERM]   = ch1_thermal_protect_i;
        sup_async[DLFS_B_CH2_MAXDUTY] = ch2_max_duty_flag_i;
        sup_async[DLFS_B_CH1_MAXDUTY] = ch1_max_duty_flag_i;
    end

    always_comb begin
        misc_async              = '0;
        misc_async[DLFS_M_RAIL] = analog_rail_low_i;
        misc_async[DLFS_M_WARN] = thermal_warning_flag_i;
    end

    dlfs_sync #(.WIDTH(DLFS_CUR_W)) u_sync_cur (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (cur_async),
        .sync_o    (cur_cause)
    );

    dlfs_sync #(.WIDTH(DLFS_SUP_W)) u_sync_sup (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (sup_async),
        .sync_o    (sup_cause)
    );

    dlfs_sync #(.WIDTH(DLFS_MISC_W)) u_sync_misc (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (misc_async),
        .sync_o    (misc_cause)
    );

    // clear waits for the response transfer, not the command transfer
    assign clr_cur = rd_resp_done_i && (rd_addr_ff == DLFS_ADDR_CURRENT);
    assign clr_sup = rd_resp_done_i && (rd_addr_ff == DLFS_ADDR_SUPPLY);
    assign clr_sys = rd_resp_done_i && (rd_addr_ff == DLFS_ADDR_SYSTEM);

    dlfs_rc_bits #(.WIDTH(DLFS_CUR_W), .RST(DLFS_RST_CURRENT)) u_rc_cur (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .cause_i   (cur_cause),
        .clear_i   (clr_cur),
        .flag_o    (cur_flag)
    );

    dlfs_rc_bits #(.WIDTH(DLFS_SUP_W), .RST(DLFS_RST_SUPPLY)) u_rc_sup (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .cause_i   (sup_cause),
        .clear_i   (clr_sup),
        .flag_o    (sup_flag)
    );

    dlfs_rc_bits #(.WIDTH(DLFS_MISC_W), .RST(DLFS_RST_MISC)) u_rc_misc (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .cause_i   (misc_cause),
        .clear_i   (clr_sys),
        .flag_o    (misc_flag)
    );

    // expiry count: a new expiry wins over the read clear
    always_comb begin
        nxt_watchdog_count = watchdog_count_ff;
        if (watchdog_expiry_i) begin
            // a fourth expiry must not wrap back to normal operation
            if (watchdog_count_ff != DLFS_WDOG_MAX) begin
                nxt_watchdog_count = watchdog_count_ff + 2'h1;
            end
        end else if (clr_sys) begin
            nxt_watchdog_count = DLFS_RST_WDOG;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            watchdog_count_ff <= DLFS_RST_WDOG;
        end else begin
            watchdog_count_ff <= nxt_watchdog_count;
        end
    end

    // fallback stays until the count is cleared by a read
    assign fallback_operation_o = (watchdog_count_ff == DLFS_WDOG_MAX);

    // power-cycle flag has no live cause once out of reset
    always_comb begin
        nxt_power_cycle = power_cycle_ff;
        if (clr_sys) begin
            nxt_power_cycle = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_cycle_ff <= DLFS_RST_POWER_CYC;
        end else begin
            power_cycle_ff <= nxt_power_cycle;
        end
    end

    // plain read-only bit, untouched by reads; enter wins over clear
    always_comb begin
        nxt_standalone = standalone_ff;
        if (standalone_enter_i) begin
            nxt_standalone = 1'b1;
        end else if (standalone_clear_i) begin
            nxt_standalone = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            standalone_ff <= DLFS_RST_STANDALONE;
        end else begin
            standalone_ff <= nxt_standalone;
        end
    end

    // thermal warning and max duty are not faults
    assign ch1_fault = cur_flag[DLFS_B_CH1_LOW_OC] | cur_flag[DLFS_B_CH1_HIGH_OC]
                     | cur_flag[DLFS_B_CH1_SHORT]  | cur_flag[DLFS_B_CH1_LOOP_OV]
                     | sup_flag[DLFS_B_CH1_THERM]  | sup_flag[DLFS_B_CH1_BOOT];
    assign ch2_fault = cur_flag[DLFS_B_CH2_LOW_OC] | cur_flag[DLFS_B_CH2_HIGH_OC]
                     | cur_flag[DLFS_B_CH2_SHORT]  | cur_flag[DLFS_B_CH2_LOOP_OV]
                     | sup_flag[DLFS_B_CH2_THERM]  | sup_flag[DLFS_B_CH2_BOOT];
    assign fault_summary_o = {ch2_fault, ch1_fault};

    always_comb begin
        sys_byte                    = '0;
        sys_byte[DLFS_B_STANDALONE] = standalone_ff;
        sys_byte[DLFS_B_RAIL_LOW]   = misc_flag[DLFS_M_RAIL];
        sys_byte[DLFS_B_WDOG_HI]    = watchdog_count_ff[1];
        sys_byte[DLFS_B_WDOG_LO]    = watchdog_count_ff[0];
        sys_byte[DLFS_B_THERM_WARN] = misc_flag[DLFS_M_WARN];
        sys_byte[DLFS_B_POWER_CYC]  = power_cycle_ff;
        sys_byte[DLFS_B_CH2_SUM]    = ch2_fault;
        sys_byte[DLFS_B_CH1_SUM]    = ch1_fault;
    end

    // read snapshot taken at the command; address kept for the later clear
    always_comb begin
        nxt_rd_addr = rd_addr_ff;
        nxt_rd_data = rd_data_ff;
        if (rd_cmd_i) begin
            nxt_rd_addr = rd_addr_i;
            case (rd_addr_i)
                DLFS_ADDR_CURRENT: nxt_rd_data = cur_flag;
                DLFS_ADDR_SUPPLY:  nxt_rd_data = {2'h0, sup_flag};
                DLFS_ADDR_SYSTEM:  nxt_rd_data = sys_byte;
                default:           nxt_rd_data = DLFS_RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_addr_ff <= DLFS_RD_UNMAPPED;
            rd_data_ff <= DLFS_RD_UNMAPPED;
        end else begin
            rd_addr_ff <= nxt_rd_addr;
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data_o = rd_data_ff;

    // a protected channel restarts only after its flag is read clear
    assign ch_enable_o[0] = ch_enable_req_i[0] & ~power_cycle_ff
                          & ~sup_flag[DLFS_B_CH1_THERM];
    assign ch_enable_o[1] = ch_enable_req_i[1] & ~power_cycle_ff
                          & ~sup_flag[DLFS_B_CH2_THERM];
endmodule

// ### design/dlfs_pkg.sv
// constants for the dual-channel fault status bank
// Behaviour
// - low-switch overcurrent sets bits 7 and 3
// - high-switch overcurrent sets bits 6 and 2
// - output short below 2.45 V, bits 5/1
// - loop node above 3.2 V, bits 4/0
// - bootstrap low bits 4/1; bits 7-6 zero
// - thermal protect bits 5/2; restart when cleared
// - max duty flag bits 3 and 0
// - standalone bit 7, cleared only by command
// - analog rail low sets bit 6
// - two-bit watchdog expiry count in bits 5-4
// - count at three enters fallback operation
// - thermal warning flag in bit 3
// - power-cycle flag bit 2, resets to one
// - channels refused while power-cycle flag set
// - summary bits OR channel faults, no warning
// - read clears set bits whose cause ended
// - clear at end of response transfer
// - first status register at address 0x03
package dlfs_pkg;
    localparam logic [7:0] DLFS_ADDR_CURRENT = 8'h03;
    localparam logic [7:0] DLFS_ADDR_SUPPLY  = 8'h04;
    localparam logic [7:0] DLFS_ADDR_SYSTEM  = 8'h05;
    localparam logic [7:0] DLFS_RD_UNMAPPED  = 8'h00;

    // current register bit positions
    localparam int DLFS_B_CH2_LOW_OC  = 7;
    localparam int DLFS_B_CH2_HIGH_OC = 6;
    localparam int DLFS_B_CH2_SHORT   = 5;
    localparam int DLFS_B_CH2_LOOP_OV = 4;
    localparam int DLFS_B_CH1_LOW_OC  = 3;
    localparam int DLFS_B_CH1_HIGH_OC = 2;
    localparam int DLFS_B_CH1_SHORT   = 1;
    localparam int DLFS_B_CH1_LOOP_OV = 0;

    // supply register bit positions
    localparam int DLFS_B_CH2_THERM   = 5;
    localparam int DLFS_B_CH2_BOOT    = 4;
    localparam int DLFS_B_CH2_MAXDUTY = 3;
    localparam int DLFS_B_CH1_THERM   = 2;
    localparam int DLFS_B_CH1_BOOT    = 1;
    localparam int DLFS_B_CH1_MAXDUTY = 0;

    // system register bit positions
    localparam int DLFS_B_STANDALONE = 7;
    localparam int DLFS_B_RAIL_LOW   = 6;
    localparam int DLFS_B_WDOG_HI    = 5;
    localparam int DLFS_B_WDOG_LO    = 4;
    localparam int DLFS_B_THERM_WARN = 3;
    localparam int DLFS_B_POWER_CYC  = 2;
    localparam int DLFS_B_CH2_SUM    = 1;
    localparam int DLFS_B_CH1_SUM    = 0;

    // widths of flag groups
    localparam int DLFS_CUR_W  = 8;
    localparam int DLFS_SUP_W  = 6;
    localparam int DLFS_MISC_W = 2;

    // reset values and expiry count limit
    localparam logic [7:0] DLFS_RST_CURRENT    = 8'h00;
    localparam logic [5:0] DLFS_RST_SUPPLY     = 6'h00;
    localparam logic [1:0] DLFS_RST_MISC       = 2'h0;
    localparam logic [1:0] DLFS_RST_WDOG       = 2'h0;
    localparam logic [1:0] DLFS_WDOG_MAX       = 2'h3;
    localparam logic       DLFS_RST_POWER_CYC  = 1'b1;
    localparam logic       DLFS_RST_STANDALONE = 1'b0;

    // misc flag indices
    localparam int DLFS_M_RAIL = 0;
    localparam int DLFS_M_WARN = 1;
endpackage

// ### design/dlfs_sync.sv
// two-stage synchroniser for asynchronous condition inputs
`timescale 1ns/1ps
module dlfs_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    // data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                end else begin
                    meta_ff[gi] <= async_i[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate

    assign sync_o = sync_ff;
endmodule

// ### design/dlfs_rc_bits.sv
// group of read-to-clear status bits with live cause inputs
`timescale 1ns/1ps
module dlfs_rc_bits #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] RST   = '0
) (
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    // cause and clear
    input  wire logic [WIDTH-1:0] cause_i,
    input  wire logic             clear_i,
    output logic      [WIDTH-1:0] flag_o
);
    logic [WIDTH-1:0] flag_ff;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic nxt_flag;
            // a live cause wins over the clear, so no event is lost
            assign nxt_flag = cause_i[gi] | (flag_ff[gi] & ~clear_i);
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    flag_ff[gi] <= RST[gi];
                end else begin
                    flag_ff[gi] <= nxt_flag;
                end
            end
        end
    endgenerate

    assign flag_o = flag_ff;
endmodule

// ### sim/dlfs_status_bank_monitor.sv
// port-level assertion checker for the fault status bank
`timescale 1ns/1ps
module dlfs_status_bank_monitor (
    input wire logic       ref_clk_i,
    input wire logic       rst_n_i,
    input wire logic       ch1_output_shorted_i,
    input wire logic       ch2_low_switch_overcurrent_i,
    input wire logic       watchdog_expiry_i,
    input wire logic       standalone_enter_i,
    input wire logic       standalone_clear_i,
    input wire logic       rd_cmd_i,
    input wire logic [7:0] rd_addr_i,
    input wire logic       rd_resp_done_i,
    input wire logic [7:0] rd_data_o,
    input wire logic [1:0] ch_enable_o,
    input wire logic       fallback_operation_o,
    input wire logic [1:0] fault_summary_o
);
    logic [7:0] last_addr_ff;
    logic [1:0] wd_cnt_ff;
    logic       pc_clr_ff;
    logic       sa_ff;
    logic       sys_done;
    logic       rd_sys;
    assign sys_done = rd_resp_done_i && (last_addr_ff == 8'h05);
    assign rd_sys   = rd_cmd_i && (rd_addr_i == 8'h05);
    // one reference block keeps the checker small
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_addr_ff <= 8'h00;
            wd_cnt_ff    <= 2'h0;
            pc_clr_ff    <= 1'b0;
            sa_ff        <= 1'b0;
        end else begin
            if (rd_cmd_i) begin
                last_addr_ff <= rd_addr_i;
            end
            if (watchdog_expiry_i && wd_cnt_ff != 2'h3) begin
                wd_cnt_ff <= wd_cnt_ff + 2'h1;
            end else if (sys_done && !watchdog_expiry_i) begin
                wd_cnt_ff <= 2'h0;
            end
            pc_clr_ff <= pc_clr_ff | sys_done;
            sa_ff     <= standalone_enter_i | (sa_ff & ~standalone_clear_i);
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_ch1_sum; ch1_output_shorted_i [*3] |=> fault_summary_o[0]; endproperty
    a_ch1_sum: assert property (p_ch1_sum) else $error("ch1 summary low");
    property p_ch2_sum; ch2_low_switch_overcurrent_i [*3] |=> fault_summary_o[1]; endproperty
    a_ch2_sum: assert property (p_ch2_sum) else $error("ch2 summary low");
    property p_pc_block; !pc_clr_ff |-> ch_enable_o == 2'b00; endproperty
    a_pc_block: assert property (p_pc_block) else $error("enable before clear");
    property p_fallback; fallback_operation_o == (wd_cnt_ff == 2'h3); endproperty
    a_fallback: assert property (p_fallback) else $error("fallback wrong");
    property p_wd_read; rd_sys |=> rd_data_o[5:4] == $past(wd_cnt_ff); endproperty
    a_wd_read: assert property (p_wd_read) else $error("expiry count wrong");
    property p_pc_read; rd_sys && !pc_clr_ff |=> rd_data_o[2]; endproperty
    a_pc_read: assert property (p_pc_read) else $error("power cycle bit low");
    property p_sa_read; rd_sys |=> rd_data_o[7] == $past(sa_ff); endproperty
    a_sa_read: assert property (p_sa_read) else $error("standalone bit wrong");
    property p_reserved; rd_cmd_i && rd_addr_i == 8'h04 |=> rd_data_o[7:6] == 2'b00; endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");
    property p_unmapped; rd_cmd_i && (rd_addr_i < 8'h03 || rd_addr_i > 8'h05) |=> rd_data_o == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
endmodule
bind dlfs_status_bank dlfs_status_bank_monitor dlfs_status_bank_monitor_inst (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ch1_output_shorted_i(ch1_output_shorted_i),
    .ch2_low_switch_overcurrent_i(ch2_low_switch_overcurrent_i), .watchdog_expiry_i(watchdog_expiry_i),
    .standalone_enter_i(standalone_enter_i), .standalone_clear_i(standalone_clear_i),
    .rd_cmd_i(rd_cmd_i), .rd_addr_i(rd_addr_i), .rd_resp_done_i(rd_resp_done_i), .rd_data_o(rd_data_o),
    .ch_enable_o(ch_enable_o), .fallback_operation_o(fallback_operation_o), .fault_summary_o(fault_summary_o)
);

// ### sim/dlfs_host_model.sv
// serial host model issuing status reads and response transfers
`timescale 1ns/1ps
module dlfs_host_model (
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] rd_data_i,
    output logic            rd_cmd_o,
    output logic      [7:0] rd_addr_o,
    output logic            rd_resp_done_o,
    output logic            got_o,
    output logic      [7:0] got_data_o
);
    initial begin
        rd_cmd_o = 1'b0;
        rd_addr_o = 8'hff;
        rd_resp_done_o = 1'b0;
        got_o = 1'b0;
        got_data_o = 8'h00;
    end
    // gap of one or more cycles; long gaps model a slow host
    task automatic read_reg(input logic [7:0] addr, input int gap);
        @(negedge ref_clk_i);
        rd_cmd_o = 1'b1;
        rd_addr_o = addr;
        @(negedge ref_clk_i);
        rd_cmd_o = 1'b0;
        rd_addr_o = ~addr; // released address does not keep its value
        got_data_o = rd_data_i;
        got_o = 1'b1;
        repeat (gap) @(negedge ref_clk_i);
        got_o = 1'b0;
        rd_resp_done_o = 1'b1;
        @(negedge ref_clk_i);
        rd_resp_done_o = 1'b0;
    endtask
endmodule

// ### sim/dlfs_status_bank_tb.sv
// self-checking testbench for the fault status bank
`timescale 1ns/1ps
module dlfs_status_bank_tb;
    logic ref_clk_i, rst_n_i, rd_cmd, rd_resp, fb, got;
    logic [7:0] cur_c, rd_addr, rd_data, got_data;
    logic [5:0] sup_c;
    logic [2:0] ev;
    logic [1:0] misc_c, en_req, ch_en, sum, s, wd;
    logic sa;
    logic [7:0] exp_q[$];
    logic [7:0] bad [4] = '{8'h00, 8'h02, 8'h06, 8'hff};
    logic [2:0] sev [5] = '{3'b000, 3'b010, 3'b000, 3'b100, 3'b110};
    int n_errors = 0;
    int n_checks = 0;
    dlfs_status_bank dlfs_status_bank_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .ch2_low_switch_overcurrent_i(cur_c[7]), .ch2_high_switch_overcurrent_i(cur_c[6]),
        .ch2_output_shorted_i(cur_c[5]), .ch2_loop_node_overvoltage_i(cur_c[4]),
        .ch1_low_switch_overcurrent_i(cur_c[3]), .ch1_high_switch_overcurrent_i(cur_c[2]),
        .ch1_output_shorted_i(cur_c[1]), .ch1_loop_node_overvoltage_i(cur_c[0]),
        .ch2_thermal_protect_i(sup_c[5]), .ch2_bootstrap_low_i(sup_c[4]), .ch2_max_duty_flag_i(sup_c[3]),
        .ch1_thermal_protect_i(sup_c[2]), .ch1_bootstrap_low_i(sup_c[1]), .ch1_max_duty_flag_i(sup_c[0]),
        .analog_rail_low_i(misc_c[0]), .thermal_warning_flag_i(misc_c[1]), .watchdog_expiry_i(ev[0]),
        .standalone_enter_i(ev[1]), .standalone_clear_i(ev[2]), .rd_cmd_i(rd_cmd), .rd_addr_i(rd_addr),
        .rd_resp_done_i(rd_resp), .rd_data_o(rd_data), .ch_enable_req_i(en_req), .ch_enable_o(ch_en),
        .fallback_operation_o(fb), .fault_summary_o(sum));
    dlfs_host_model dlfs_host_model_inst (.ref_clk_i(ref_clk_i), .rd_data_i(rd_data), .rd_cmd_o(rd_cmd),
        .rd_addr_o(rd_addr), .rd_resp_done_o(rd_resp), .got_o(got), .got_data_o(got_data));
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_sum(input logic [1:0] e);
        cmp({6'h0, sum}, {6'h0, e});
    endtask
    task automatic cmp_en(input logic [1:0] e);
        cmp({6'h0, ch_en}, {6'h0, e});
    endtask
    task automatic cmp_fb(input logic e);
        cmp({7'h0, fb}, {7'h0, e});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input int gap = 1);
        exp_q.push_back(e);
        dlfs_host_model_inst.read_reg(a, gap);
    endtask
    task automatic pulse(input logic [2:0] v);
        @(negedge ref_clk_i);
        ev = v;
        @(negedge ref_clk_i);
        ev = 3'b000;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge got) begin
        if (exp_q.size() != 0) begin
            cmp(got_data, exp_q.pop_front());
        end else begin
            n_errors++;
        end
    end
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #800000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        logic [31:0] r;
        rst_n_i = 1'b0; cur_c = 8'h00; sup_c = 6'h00; misc_c = 2'h0; ev = 3'h0; en_req = 2'h3;
        sa = 1'b0;
        void'($urandom(31388));
        repeat (20) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        cmp_en(2'h0);
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h00);
        foreach (bad[i]) rd(bad[i], 8'h00);
        rd(8'h05, 8'h04);
        cmp_en(2'h3);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            r = $urandom();
            cur_c = r[7:0]; sup_c = r[13:8]; misc_c = r[15:14];
            s = {|r[7:4] | r[13] | r[12], |r[3:0] | r[10] | r[9]};
            repeat (4) @(negedge ref_clk_i);
            cmp_sum(s);
            cmp_en({~r[13], ~r[10]});
            rd(8'h03, r[7:0]);
            rd(8'h04, {2'b00, r[13:8]});
            rd(8'h05, {1'b0, r[14], 2'b00, r[15], 1'b0, s});
            cur_c = 8'h00; sup_c = 6'h00; misc_c = 2'h0;
            repeat (4) @(negedge ref_clk_i);
            fork
                rd(8'h03, r[7:0], 6);
                begin repeat (3) @(negedge ref_clk_i); cmp_sum(s); end
            join
            rd(8'h04, {2'b00, r[13:8]});
            rd(8'h05, {1'b0, r[14], 2'b00, r[15], 3'b000});
            rd(8'h05, 8'h00);
            cmp_sum(2'h0);
            cmp_en(2'h3);
        end
        $display("test flags done");
        for (int k = 0; k < 5; k++) begin
            for (int j = 0; j < k; j++) pulse(3'b001);
            pulse(sev[k]);
            sa = sev[k][1] | (sa & ~sev[k][2]);
            wd = (k > 3) ? 2'h3 : 2'(k);
            cmp_fb(wd == 2'h3);
            rd(8'h05, {sa, 1'b0, wd, 4'h0});
        end
        // expiry lands in the clearing cycle of a status read: the count must keep it
        fork
            rd(8'h05, 8'h80);
            begin repeat (2) @(negedge ref_clk_i); pulse(3'b001); end
        join
        rd(8'h05, 8'h90);
        $display("test watchdog done");
        rst_n_i = 1'b0;
        repeat (20) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        cmp_en(2'h0);
        rd(8'h05, 8'h04);
        repeat (2) @(negedge ref_clk_i);
        if (exp_q.size() != 0) n_errors++;
        $display("test second reset done");
        report_and_stop();
    end
endmodule
